/* File: rtl/pld_defines.svh */
`ifndef PLD_DEFINES_SVH
`define PLD_DEFINES_SVH
// Register offsets
`define PLD_OFS_RDIV   5'h02
`define PLD_OFS_NINT   5'h03
`define PLD_OFS_MODE   5'h06
`define PLD_OFS_LDC    5'h07
`define PLD_OFS_REFC   5'h08
`define PLD_OFS_CPC    5'h09
`define PLD_OFS_PDC    5'h0B
`define PLD_OFS_OUTC   5'h0F
`define PLD_OFS_STAT   5'h12
// Field positions
`define PLD_CP_DNG_LSB 0
`define PLD_CP_UPG_LSB 7
`define PLD_CP_OFS_LSB 14
`define PLD_CP_OFSUP   21
`define PLD_CP_OFSDN   22
`define PLD_PD_UPEN    5
`define PLD_PD_DNEN    6
`define PLD_PD_FUP     9
`define PLD_PD_FDN     10
`define PLD_REF_PRESC  19
`define PLD_REF_HF     21
`define PLD_LD_THR_LSB 0
`define PLD_LD_EN      3
`define PLD_LD_DIG     6
`define PLD_LD_WIN_LSB 7
`define PLD_OUT_SEL_LSB 0
`define PLD_OUT_LD_EN  7
`define PLD_OUT_SEL_LD 5'h01
`define PLD_MODE_FRAC  11
`define PLD_STAT_LOCK  1
// Reset values
`define PLD_RST_RDIV   24'h000001
`define PLD_RST_NINT   24'h000014
`define PLD_RST_PDC    24'h000060
`define PLD_RST_ZERO   24'h000000
// Divider limits
`define PLD_N_MIN_FRAC 19'd20
`define PLD_N_MAX_FRAC 19'd524283
`define PLD_N_MIN_INT  19'd16
`define PLD_N_MAX_INT  19'd524287
// Timing
`define PLD_CLK_PS     25000
`define PLD_AWIN_PS    10000
`define PLD_AWIN_CYC   ((`PLD_AWIN_PS / `PLD_CLK_PS) < 1 ? 1 : \
                        (`PLD_AWIN_PS / `PLD_CLK_PS))
`endif

/* File: rtl/pld_pkg.sv */
package pld_pkg;
    typedef logic [23:0] pld_reg_t;
    typedef enum logic [1:0] {
        LD_IDLE     = 2'b00,
        LD_WAIT_FB  = 2'b01,
        LD_WAIT_REF = 2'b10
    } pld_ld_state_t;
    // Digital window widths in ps, index {speed, divide}
    typedef int unsigned pld_win_tab_t [32];
    localparam pld_win_tab_t PLD_DWIN_PS = '{
        6500, 8000, 11000, 17000, 29000, 53000, 100000, 195000,
        7000, 8900, 12800, 21000, 36000, 68000, 130000, 255000,
        7100, 9200, 13300, 22000, 38000, 72000, 138000, 272000,
        7600, 10200, 15400, 26000, 47000, 88000, 172000, 338000
    };
endpackage

/* File: rtl/pld_lock_if.sv */
`timescale 1ns/1ps
interface pld_lock_if;
    logic       ref_edge;
    logic       fb_edge;
    logic       enable;
    logic       digital;
    logic [4:0] win_sel;
    logic [2:0] threshold;
    logic       locked;
    modport core (output ref_edge, fb_edge, enable, digital, win_sel,
                  threshold, input locked);
    modport det  (input ref_edge, fb_edge, enable, digital, win_sel,
                  threshold, output locked);
endinterface

/* File: rtl/pld_lock_detect.sv */
`timescale 1ns/1ps
`include "pld_defines.svh"
module pld_lock_detect
    import pld_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    pld_lock_if.det  lk
);
    pld_ld_state_t state;
    logic [4:0]    timer;
    logic [2:0]    count;
    logic [4:0]    win_cyc;
    logic          hit;
    logic          miss;
    logic [3:0]    next_count;

    // Window length in clock cycles, never below one
    always_comb
    begin
        if (!lk.digital)
            win_cyc = 5'(`PLD_AWIN_CYC); // R19
        else if (PLD_DWIN_PS[lk.win_sel] < `PLD_CLK_PS)
            win_cyc = 5'h01;
        else
            win_cyc = 5'(PLD_DWIN_PS[lk.win_sel] / `PLD_CLK_PS); // R20 R21
    end

    // Window outcome of the current comparison cycle
    always_comb
    begin
        hit  = 1'b0;
        miss = 1'b0;
        case (state)
            LD_IDLE:     hit  = lk.ref_edge && lk.fb_edge;
            LD_WAIT_FB:
            begin
                hit  = lk.fb_edge; // R16
                miss = !lk.fb_edge && (timer >= win_cyc);
            end
            LD_WAIT_REF:
            begin
                hit  = lk.ref_edge; // R16
                miss = !lk.ref_edge && (timer >= win_cyc);
            end
            default:     miss = 1'b0;
        endcase
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            state <= LD_IDLE;
            timer <= 5'h00;
        end
        else if (!lk.enable)
        begin
            state <= LD_IDLE; // R14
            timer <= 5'h00;
        end
        else if (hit || miss)
        begin
            state <= LD_IDLE;
            timer <= 5'h00;
        end
        else if (state == LD_IDLE && lk.ref_edge)
        begin
            state <= LD_WAIT_FB;
            timer <= 5'h01;
        end
        else if (state == LD_IDLE && lk.fb_edge)
        begin
            state <= LD_WAIT_REF;
            timer <= 5'h01;
        end
        else if (state != LD_IDLE)
            timer <= timer + 5'h01;
    end

    assign next_count = (count == 3'h7) ? 4'h7 : {1'b0, count} + 4'h1;

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            count     <= 3'h0;
            lk.locked <= 1'b0;
        end
        else if (!lk.enable)
        begin
            count     <= 3'h0; // R14
            lk.locked <= 1'b0;
        end
        else if (miss)
        begin
            count     <= 3'h0; // R18
            lk.locked <= 1'b0;
        end
        else if (hit)
        begin
            count     <= next_count[2:0]; // R16
            lk.locked <= next_count >= {1'b0, lk.threshold}; // R17
        end
    end

    AST_OFF_NO_LOCK: assert property (@(posedge CLK) disable iff (RST)
        !lk.enable |=> !lk.locked && count == 3'h0) // R14
        else $error("lock held while detector disabled");
    AST_MISS_UNLOCK: assert property (@(posedge CLK) disable iff (RST)
        lk.enable && miss |=> !lk.locked && count == 3'h0) // R18
        else $error("missed window did not clear lock");
    AST_HIT_COUNT: assert property (@(posedge CLK) disable iff (RST)
        lk.enable && hit && count != 3'h7 |=> count == $past(count) + 3'h1) // R16
        else $error("in-window cycle not counted");
    AST_LOCK_THR: assert property (@(posedge CLK) disable iff (RST)
        lk.enable && hit && count >= lk.threshold |=> lk.locked) // R17
        else $error("lock not declared at threshold");
    AST_LOCK_HOLD: assert property (@(posedge CLK) disable iff (RST)
        lk.enable && lk.locked && !miss |=> lk.locked) // R24
        else $error("lock dropped between evaluations");
    AST_WIN_BOUND: assert property (@(posedge CLK) disable iff (RST)
        state != LD_IDLE |-> timer <= win_cyc) // R19
        else $error("window timer overran");
endmodule

/* File: rtl/pld_core.sv */
`timescale 1ns/1ps
`include "pld_defines.svh"
// Function
// [R1] Charge pump up/down gains from fields
// [R2] Offset magnitude and direction bits taken
// [R3] Integer mode: host zeroes offset settings
// [R4] Fractional mode: host uses up offset
// [R5] Up mask bit clear blocks up
// [R6] Down mask bit clear blocks down
// [R7] Both masks clear tri-states charge pump
// [R8] Force bits drive pump up or down
// [R9] Reference buffer mode select bit
// [R10] Fourteen-bit reference divider, 1 to 16383
// [R11] Feedback divider ratio limits per mode
// [R12] Host enables prescaler at high output
// [R13] Host limits comparison rate per mode
// [R14] Lock detector runs only when enabled
// [R15] Lock state readable in status bit
// [R16] Count in-window edge pairs, either order
// [R17] Lock at count reaching threshold
// [R18] Window miss clears count and lock
// [R19] Analog mode uses fixed 10 ns window; code uses one 25 ns clock cycle
// [R20] Digital mode window from field
// [R21] Window field: speed and divide subfields
// [R22] Lock flag on shared pin when selected
// [R23] Mode bit selects fractional or integer
// [R24] Lock held stable between evaluations
module pld_core
    import pld_pkg::*;
#(
    parameter int RDIV_W = 14,
    parameter int NDIV_W = 19
)
(
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        REG_WE,
    input  wire logic [4:0]  REG_ADDR,
    input  wire logic [23:0] REG_WDATA,
    output logic      [23:0] REG_RDATA,
    input  wire logic        REF_IN,
    input  wire logic        VCO_IN,
    output logic             CP_UP,
    output logic             CP_DN,
    output logic             CP_HIZ,
    output logic      [6:0]  CP_UP_GAIN,
    output logic      [6:0]  CP_DN_GAIN,
    output logic      [6:0]  CP_OFFSET,
    output logic             CP_OFFSET_UP,
    output logic             CP_OFFSET_DN,
    output logic             REF_BUF_HIGH_FREQ,
    output logic             PRESCALER_EN,
    output logic             FRAC_MODE,
    output logic             LOCKED,
    output logic             LOCK_OR_SERIAL_OUT_PIN
);
    if (RDIV_W != 14)
        $error("reference divider must be 14 bits");
    if (NDIV_W != 19)
        $error("feedback divider must be 19 bits");

    pld_reg_t    rdiv_reg;
    pld_reg_t    nint_reg;
    pld_reg_t    mode_reg;
    pld_reg_t    ldc_reg;
    pld_reg_t    refc_reg;
    pld_reg_t    cpc_reg;
    pld_reg_t    pdc_reg;
    pld_reg_t    outc_reg;

    logic              ref_q;
    logic              vco_q;
    logic              ref_rise;
    logic              vco_rise;
    logic              presc_tog;
    logic              fb_tick;
    logic [RDIV_W-1:0] rcnt;
    logic [RDIV_W-1:0] r_ratio;
    logic              ref_div;
    logic [NDIV_W-1:0] ncnt;
    logic [NDIV_W-1:0] n_raw;
    logic [NDIV_W-1:0] n_ratio;
    logic              fb_div;
    logic              pfd_up;
    logic              pfd_dn;
    logic              next_up;
    logic              next_dn;
    logic              f_up;
    logic              f_dn;
    logic              en_up;
    logic              en_dn;
    logic              frac;

    pld_lock_if lk ();

    // Register writes
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            rdiv_reg <= `PLD_RST_RDIV;
            nint_reg <= `PLD_RST_NINT;
            mode_reg <= `PLD_RST_ZERO;
            ldc_reg  <= `PLD_RST_ZERO;
            refc_reg <= `PLD_RST_ZERO;
            cpc_reg  <= `PLD_RST_ZERO;
            pdc_reg  <= `PLD_RST_PDC;
            outc_reg <= `PLD_RST_ZERO;
        end
        else if (REG_WE)
        begin
            case (REG_ADDR)
                `PLD_OFS_RDIV: rdiv_reg <= REG_WDATA; // R10
                `PLD_OFS_NINT: nint_reg <= REG_WDATA;
                `PLD_OFS_MODE: mode_reg <= REG_WDATA;
                `PLD_OFS_LDC:  ldc_reg  <= REG_WDATA;
                `PLD_OFS_REFC: refc_reg <= REG_WDATA;
                `PLD_OFS_CPC:  cpc_reg  <= REG_WDATA;
                `PLD_OFS_PDC:  pdc_reg  <= REG_WDATA;
                `PLD_OFS_OUTC: outc_reg <= REG_WDATA;
                default:       ldc_reg  <= ldc_reg;
            endcase
        end
    end

    // Register read, one cycle after the address
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            REG_RDATA <= `PLD_RST_ZERO;
        else
        begin
            case (REG_ADDR)
                `PLD_OFS_RDIV: REG_RDATA <= rdiv_reg;
                `PLD_OFS_NINT: REG_RDATA <= nint_reg;
                `PLD_OFS_MODE: REG_RDATA <= mode_reg;
                `PLD_OFS_LDC:  REG_RDATA <= ldc_reg;
                `PLD_OFS_REFC: REG_RDATA <= refc_reg;
                `PLD_OFS_CPC:  REG_RDATA <= cpc_reg;
                `PLD_OFS_PDC:  REG_RDATA <= pdc_reg;
                `PLD_OFS_OUTC: REG_RDATA <= outc_reg;
                `PLD_OFS_STAT: REG_RDATA <=
                    24'(lk.locked) << `PLD_STAT_LOCK; // R15
                default:       REG_RDATA <= `PLD_RST_ZERO;
            endcase
        end
    end

    // Static fields straight from the configuration flops
    assign CP_UP_GAIN   = cpc_reg[`PLD_CP_UPG_LSB +: 7]; // R1
    assign CP_DN_GAIN   = cpc_reg[`PLD_CP_DNG_LSB +: 7]; // R1
    assign CP_OFFSET    = cpc_reg[`PLD_CP_OFS_LSB +: 7]; // R2
    assign CP_OFFSET_UP = cpc_reg[`PLD_CP_OFSUP]; // R2 R4
    assign CP_OFFSET_DN = cpc_reg[`PLD_CP_OFSDN]; // R2 R3
    assign REF_BUF_HIGH_FREQ = refc_reg[`PLD_REF_HF]; // R9
    assign PRESCALER_EN = refc_reg[`PLD_REF_PRESC]; // R12
    assign FRAC_MODE    = mode_reg[`PLD_MODE_FRAC]; // R23
    assign frac         = mode_reg[`PLD_MODE_FRAC];

    // Input edge detection
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            ref_q <= 1'b0;
            vco_q <= 1'b0;
        end
        else
        begin
            ref_q <= REF_IN;
            vco_q <= VCO_IN;
        end
    end

    assign ref_rise = REF_IN && !ref_q;
    assign vco_rise = VCO_IN && !vco_q;

    // Prescaler halves the feedback edge rate
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            presc_tog <= 1'b0;
        else if (vco_rise)
            presc_tog <= !presc_tog;
    end

    assign fb_tick = vco_rise && (!PRESCALER_EN || presc_tog); // R12

    // Reference divider, zero treated as one
    assign r_ratio = (rdiv_reg[RDIV_W-1:0] == '0) ? RDIV_W'(1)
                                                 : rdiv_reg[RDIV_W-1:0];

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            rcnt    <= '0;
            ref_div <= 1'b0;
        end
        else
        begin
            ref_div <= 1'b0;
            if (ref_rise)
            begin
                if (rcnt >= r_ratio - RDIV_W'(1))
                begin
                    rcnt    <= '0; // R10
                    ref_div <= 1'b1;
                end
                else
                    rcnt <= rcnt + RDIV_W'(1);
            end
        end
    end

    // Feedback ratio clamped to the range of the mode
    always_comb
    begin
        n_raw = nint_reg[NDIV_W-1:0];
        if (frac && n_raw < `PLD_N_MIN_FRAC)
            n_ratio = `PLD_N_MIN_FRAC; // R11 R23
        else if (frac && n_raw > `PLD_N_MAX_FRAC)
            n_ratio = `PLD_N_MAX_FRAC; // R11
        else if (!frac && n_raw < `PLD_N_MIN_INT)
            n_ratio = `PLD_N_MIN_INT; // R11
        else
            n_ratio = n_raw;
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            ncnt   <= '0;
            fb_div <= 1'b0;
        end
        else
        begin
            fb_div <= 1'b0;
            if (fb_tick)
            begin
                if (ncnt >= n_ratio - NDIV_W'(1))
                begin
                    ncnt   <= '0; // R11
                    fb_div <= 1'b1;
                end
                else
                    ncnt <= ncnt + NDIV_W'(1);
            end
        end
    end

    // Phase frequency detector state
    always_comb
    begin
        next_up = pfd_up || ref_div;
        next_dn = pfd_dn || fb_div;
        if (next_up && next_dn)
        begin
            next_up = 1'b0;
            next_dn = 1'b0;
        end
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            pfd_up <= 1'b0;
            pfd_dn <= 1'b0;
        end
        else
        begin
            pfd_up <= next_up;
            pfd_dn <= next_dn;
        end
    end

    assign f_up  = pdc_reg[`PLD_PD_FUP];
    assign f_dn  = pdc_reg[`PLD_PD_FDN];
    assign en_up = pdc_reg[`PLD_PD_UPEN];
    assign en_dn = pdc_reg[`PLD_PD_DNEN];

    // Charge pump drive: force first, then masked detector
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            CP_UP  <= 1'b0;
            CP_DN  <= 1'b0;
            CP_HIZ <= 1'b1;
        end
        else
        begin
            CP_UP  <= f_up || (!f_dn && en_up && pfd_up); // R5 R8
            CP_DN  <= !f_up && (f_dn || (en_dn && pfd_dn)); // R6 R8
            CP_HIZ <= !f_up && !f_dn && !en_up && !en_dn; // R7
        end
    end

    // Lock detector hookup
    assign lk.ref_edge  = ref_div;
    assign lk.fb_edge   = fb_div;
    assign lk.enable    = ldc_reg[`PLD_LD_EN]; // R14
    assign lk.digital   = ldc_reg[`PLD_LD_DIG]; // R19 R20
    assign lk.win_sel   = ldc_reg[`PLD_LD_WIN_LSB +: 5]; // R21
    assign lk.threshold = ldc_reg[`PLD_LD_THR_LSB +: 3]; // R17

    pld_lock_detect u_lock (
        .CLK (CLK),
        .RST (RST),
        .lk  (lk.det)
    );

    // Lock outputs
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            LOCKED                 <= 1'b0;
            LOCK_OR_SERIAL_OUT_PIN <= 1'b0;
        end
        else
        begin
            LOCKED                 <= lk.locked; // R15
            LOCK_OR_SERIAL_OUT_PIN <= outc_reg[`PLD_OUT_LD_EN] &&
                (outc_reg[`PLD_OUT_SEL_LSB +: 5] == `PLD_OUT_SEL_LD) &&
                lk.locked; // R22
        end
    end

    AST_UP_MASK: assert property (@(posedge CLK) disable iff (RST)
        !en_up && !f_up |=> !CP_UP) // R5
        else $error("up pulse passed while masked");
    AST_DN_MASK: assert property (@(posedge CLK) disable iff (RST)
        !en_dn && !f_dn |=> !CP_DN) // R6
        else $error("down pulse passed while masked");
    AST_HIZ: assert property (@(posedge CLK) disable iff (RST)
        !en_up && !en_dn && !f_up && !f_dn |=> CP_HIZ && !CP_UP && !CP_DN) // R7
        else $error("charge pump not tri-stated");
    AST_FORCE: assert property (@(posedge CLK) disable iff (RST)
        f_up |=> CP_UP && !CP_DN && !CP_HIZ) // R8
        else $error("force up not applied");
    AST_RDIV: assert property (@(posedge CLK) disable iff (RST)
        ref_div |-> rcnt == '0) // R10
        else $error("reference divider terminal count wrong");
    AST_NRANGE: assert property (@(posedge CLK) disable iff (RST)
        frac |-> n_ratio >= `PLD_N_MIN_FRAC && n_ratio <= `PLD_N_MAX_FRAC) // R11
        else $error("fractional ratio out of range");
    AST_STATUS: assert property (@(posedge CLK) disable iff (RST)
        REG_ADDR == `PLD_OFS_STAT ##1 1'b1 |->
        REG_RDATA[`PLD_STAT_LOCK] == LOCKED) // R15
        else $error("status bit disagrees with lock");
    AST_PIN: assert property (@(posedge CLK) disable iff (RST)
        outc_reg[`PLD_OUT_LD_EN] && outc_reg[4:0] == `PLD_OUT_SEL_LD
        && $stable(outc_reg) |=> LOCK_OR_SERIAL_OUT_PIN == LOCKED) // R22
        else $error("lock pin does not follow lock");
endmodule

/* File: tb/pld_src_model.sv */
`timescale 1ns/1ps
module pld_src_model (
    input  wire logic CLK,
    input  wire logic start,
    input  wire logic signed [31:0] skew,
    input  wire logic signed [31:0] nper,
    output logic      ref_out,
    output logic      vco_out,
    output logic      busy
);
    // Each period: 16 feedback rises, one reference rise at 30 + skew
    initial
    begin
        ref_out = 1'b0;
        vco_out = 1'b0;
        busy = 1'b0;
        forever
        begin
            @(posedge CLK);
            if (start)
            begin
                @(negedge CLK);
                busy = 1'b1;
                // 40-cycle period keeps the comparison rate low
                for (int p = 0; p < nper; p++)
                    for (int c = 0; c < 40; c++)
                    begin
                        ref_out = (c == 30 + skew);
                        vco_out = (c < 31) && (c % 2 == 0);
                        @(negedge CLK);
                    end
                // Quiet between bursts so divider counts stay whole
                ref_out = 1'b0;
                vco_out = 1'b0;
                busy = 1'b0;
            end
        end
    end
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top
    import pld_pkg::*;
;
    logic        CLK, RST, REG_WE, REF_IN, VCO_IN;
    logic [4:0]  REG_ADDR;
    pld_reg_t    REG_WDATA, REG_RDATA, v;
    logic        CP_UP, CP_DN, CP_HIZ, CP_OFFSET_UP, CP_OFFSET_DN;
    logic [6:0]  CP_UP_GAIN, CP_DN_GAIN, CP_OFFSET;
    logic        REF_BUF_HIGH_FREQ, PRESCALER_EN, FRAC_MODE, LOCKED;
    logic        LOCK_OR_SERIAL_OUT_PIN;
    logic        start, busy, seen_up, seen_dn, pin_on;
    int          skew, nper, err_total, n_checks, cyc;
    pld_reg_t    exp_q[$], msk_q[$];
    event        rd_ev;
    pld_reg_t    pdf[4] = '{24'h000260, 24'h000460, 24'h000660, 24'h000000};
    logic [2:0]  pdx[4] = '{3'b010, 3'b001, 3'b010, 3'b100};
    pld_reg_t    pmv[4] = '{24'h000040, 24'h000020, 24'h000060, 24'h000060};
    int          psk[4] = '{-5, 5, 5, -5};
    logic [3:0]  pup = 4'h9;
    logic [3:0]  pex = 4'hC;
    pld_reg_t    ldc[9] = '{24'h00000B, 24'h00000B, 24'h00000B, 24'h0003CB,
                            24'h0003CB, 24'h000FCB, 24'h00004B, 24'h00000F,
                            24'h00000F};
    int          lnp[9] = '{6, 2, 6, 6, 2, 6, 2, 4, 4};
    int          lsk[9] = '{0, -6, 1, -4, -10, -10, -4, 0, 0};
    logic [8:0]  lex = 9'h12D;
    pld_reg_t    pnv[3] = '{24'h000082, 24'h000001, 24'h000081};

    pld_core #(.RDIV_W(14), .NDIV_W(19)) pld_core_i (
        .CLK(CLK), .RST(RST), .REG_WE(REG_WE), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .REF_IN(REF_IN),
        .VCO_IN(VCO_IN), .CP_UP(CP_UP), .CP_DN(CP_DN), .CP_HIZ(CP_HIZ),
        .CP_UP_GAIN(CP_UP_GAIN), .CP_DN_GAIN(CP_DN_GAIN),
        .CP_OFFSET(CP_OFFSET), .CP_OFFSET_UP(CP_OFFSET_UP),
        .CP_OFFSET_DN(CP_OFFSET_DN), .REF_BUF_HIGH_FREQ(REF_BUF_HIGH_FREQ),
        .PRESCALER_EN(PRESCALER_EN), .FRAC_MODE(FRAC_MODE), .LOCKED(LOCKED),
        .LOCK_OR_SERIAL_OUT_PIN(LOCK_OR_SERIAL_OUT_PIN));

    pld_src_model pld_src_model_i (
        .CLK(CLK), .start(start), .skew(skew), .nper(nper),
        .ref_out(REF_IN), .vco_out(VCO_IN), .busy(busy));

    initial
    begin
        CLK = 1'b0;
        forever #12.5 CLK = ~CLK;
    end

    // Pump activity flags and run-time ceiling
    always @(posedge CLK)
    begin
        cyc <= cyc + 1;
        if (CP_UP === 1'b1)
            seen_up <= 1'b1;
        if (CP_DN === 1'b1)
            seen_dn <= 1'b1;
        if (cyc == 20000)
        begin
            err_total++;
            close_out();
        end
    end

    // Read results are compared against the oldest note
    initial
        forever
        begin
            @(rd_ev);
            chk("REG_RDATA", REG_RDATA & msk_q[0], exp_q[0] & msk_q[0]);
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end

    task automatic chk(string nm, pld_reg_t seen, pld_reg_t exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(logic [4:0] a, pld_reg_t d);
        @(negedge CLK);
        REG_WE = 1'b1;
        REG_ADDR = a;
        REG_WDATA = d;
        @(negedge CLK);
        REG_WE = 1'b0;
    endtask

    task automatic rd(logic [4:0] a, pld_reg_t e, pld_reg_t m);
        @(negedge CLK);
        REG_ADDR = a;
        exp_q.push_back(e);
        msk_q.push_back(m);
        repeat (2) @(posedge CLK);
        #1;
        ->rd_ev;
    endtask

    task automatic run(int n, int d);
        @(negedge CLK);
        skew = d;
        nper = n;
        start = 1'b1;
        @(negedge CLK);
        start = 1'b0;
        @(posedge CLK);
        while (busy === 1'b1)
            @(posedge CLK);
        // Room for the window to close and the flag to land
        repeat (16) @(negedge CLK);
    endtask

    task automatic lk(logic e);
        chk("LOCKED", {23'h0, LOCKED}, {23'h0, e});
        chk("LOCK_PIN", {23'h0, LOCK_OR_SERIAL_OUT_PIN},
            {23'h0, e & pin_on});
        rd(5'h12, {22'h0, e, 1'b0}, 24'h000002);
    endtask

    task automatic close_out();
        $display("Checks %0d, errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        {RST, REG_WE, REG_ADDR, REG_WDATA, start, pin_on} = '0;
        RST = 1'b1;
        {skew, nper, err_total, n_checks, cyc} = '0;
        {seen_up, seen_dn} = 2'b00;
        void'($urandom(32'h0E7AB511));
        repeat (20) @(posedge CLK);
        @(negedge CLK);
        RST = 1'b0;
        rd(5'h02, 24'h000001, 24'hFFFFFF);
        rd(5'h03, 24'h000014, 24'hFFFFFF);
        rd(5'h0B, 24'h000060, 24'hFFFFFF);
        rd(5'h07, 24'h000000, 24'hFFFFFF);
        rd(5'h09, 24'h000000, 24'hFFFFFF);
        wr(5'h02, 24'h003FFF);
        rd(5'h02, 24'h003FFF, 24'hFFFFFF);
        wr(5'h03, 24'h07FFFF);
        rd(5'h03, 24'h07FFFF, 24'hFFFFFF);
        wr(5'h12, 24'hFFFFFF);
        wr(5'h1F, 24'hFFFFFF);
        rd(5'h12, 24'h000000, 24'h000002);
        rd(5'h1F, 24'h000000, 24'hFFFFFF);
        for (int i = 0; i < 4; i++)
        begin
            v = $urandom & 24'h7FFFFF;
            wr(5'h09, v);
            @(negedge CLK);
            chk("CP_FIELDS", {1'b0, CP_OFFSET_DN, CP_OFFSET_UP, CP_OFFSET,
                CP_UP_GAIN, CP_DN_GAIN}, v);
            rd(5'h09, v, 24'hFFFFFF);
            v = {2'b0, i[1], 1'b0, i[0], 19'h0};
            wr(5'h08, v);
            @(negedge CLK);
            chk("REF_CFG", {22'h0, REF_BUF_HIGH_FREQ, PRESCALER_EN},
                {22'h0, v[21], v[19]});
        end
        // Fractional: up offset only, a quarter of the gain
        wr(5'h06, 24'h000800);
        wr(5'h09, 24'h267264);
        @(negedge CLK);
        chk("FRAC_MODE", {23'h0, FRAC_MODE}, 24'h000001);
        wr(5'h06, 24'h000000);
        wr(5'h09, 24'h003264);
        @(negedge CLK);
        chk("FRAC_MODE", {23'h0, FRAC_MODE}, 24'h000000);
        wr(5'h02, 24'h000001);
        wr(5'h03, 24'h000010);
        // Prescaler off so each period closes one whole feedback count
        wr(5'h08, 24'h000000);
        for (int i = 0; i < 4; i++)
        begin
            wr(5'h0B, pdf[i]);
            repeat (3) @(negedge CLK);
            chk("CP_DRIVE", {21'h0, CP_HIZ, CP_UP, CP_DN},
                {21'h0, pdx[i]});
        end
        for (int i = 0; i < 4; i++)
        begin
            wr(5'h0B, pmv[i]);
            seen_up = 1'b0;
            seen_dn = 1'b0;
            run(2, psk[i]);
            chk("CP_PULSE", {23'h0, pup[i] ? seen_up : seen_dn},
                {23'h0, pex[i]});
        end
        wr(5'h0F, 24'h000081);
        pin_on = 1'b1;
        for (int i = 0; i < 9; i++)
        begin
            // Rewrites are skipped so the hit count is not disturbed
            if (i == 0 || ldc[i] !== ldc[i - 1])
                wr(5'h07, ldc[i]);
            run(lnp[i], lsk[i]);
            lk(lex[i]);
            repeat (20) @(negedge CLK);
            lk(lex[i]);
        end
        for (int i = 0; i < 3; i++)
        begin
            wr(5'h0F, pnv[i]);
            @(negedge CLK);
            chk("LOCK_PIN", {23'h0, LOCK_OR_SERIAL_OUT_PIN},
                {23'h0, i == 2});
        end
        wr(5'h07, 24'h000007);
        repeat (4) @(negedge CLK);
        lk(1'b0);
        run(4, 0);
        lk(1'b0);
        close_out();
    end
endmodule
